// ===== logic/rsft_frame_timing.sv
// Rolling shutter frame timing sequencer with APB register slave
// What this block does
// - Single-frame mode starts a frame's integration only on a frame_sync assertion.
// - Each row is read only after its own integration ends; rows staggered.
// - After the last single-frame row is read, stay idle until a new sync.
// - Only pixels inside the window given by pointer, depth and width are output.
// - Subsample steps are one pixel in mono space, two in Bayer space.
// - Full, half, quarter, eighth rates independently for rows and columns.
// - Setting x0010101 gives Bayer read one pattern skip one both ways.
// - Continuous frame period is virtual row depth plus one row times.
// - Integration time is integration count plus one row times.
// - Row time is column width plus both sample-hold counts plus 19 clocks.
// - In continuous mode integration never exceeds the frame period.
// - Single frame lasts integration time plus depth-plus-one row readout.
// - Single-frame integration uses same formula, not capped by frame period.
// - Integration count is built from a high and a low register.
// - Virtual row depth is built from a register pair.
// - Virtual column width is built from a register pair.
// - Signal and reset sample-hold counts each have their own register.
// - Capture mode is chosen by bit 6 of the control register.
// - Continuous mode after reset; integration and readout run in parallel.
// - Continuous mode starts the next frame's first row automatically.
`timescale 1ns/10ps
`default_nettype none
module rsft_frame_timing
   import rsft_pkg::*;
(
   input wire logic sys_clk, // Master clock, 20 MHz
   input wire logic rst_n, // Synchronous reset, active low
   input wire logic psel, // APB select
   input wire logic penable, // APB enable
   input wire logic pwrite, // APB direction
   input wire logic [7:0] paddr, // APB byte address
   input wire logic [31:0] pwdata, // APB write data
   output logic [31:0] prdata, // APB read data
   output logic pready, // APB ready
   output logic pslverr, // APB error for unmapped address
   input wire logic frameSync, // Frame sync from host, asynchronous
   output logic integStart, // Pulse: a row starts integrating
   output logic [15:0] integRow, // Row that starts integrating
   output logic readStart, // Pulse: a row starts readout
   output logic [15:0] readRow, // Row being read out
   output rsft_pix_s pixOut // Window pixel stream
);
   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic [7:0] ctrl;
      rsft_cfg_s sw;
      rsft_cfg_s act;
      logic [2:0] syncPipe;
      logic syncLvl;
      logic syncPend;
      rsft_phase_e phase;
      logic [17:0] clkCnt;
      logic [15:0] rowCnt;
      logic [15:0] intCnt;
      logic readActive;
      logic integRun;
      logic lagRun;
      logic [15:0] readRowN;
      logic integStart;
      logic [15:0] integRow;
      logic readStart;
      rsft_pix_s pix;
   } rsft_state_s;

   rsft_state_s stReg, stNext;
   logic apbAcc;
   logic [17:0] rowLen;
   logic rowEnd;
   logic [15:0] rowStep;
   logic [15:0] colStep;
   logic [15:0] rowOff;
   logic [15:0] colOff;
   logic [15:0] readLast;
   logic [16:0] lagRows;
   logic singleMode;

   // Step from rate code: 1,2,4,8 units, doubled in Bayer space
   function automatic logic [15:0] stepOf(input logic [1:0] rate, input logic bayer);
      logic [15:0] s;
      s = 16'h0001 << rate;
      return bayer ? {s[14:0], 1'b0} : s;
   endfunction

   // Bayer keeps pairs: offset inside the pattern passes, the rest steps
   function automatic logic inSample(input logic [15:0] off, input logic [15:0] step,
                                     input logic bayer);
      logic [15:0] m;
      m = off & (step - 16'h0001);
      return bayer ? (m[15:1] == 15'h0000) : (m == 16'h0000);
   endfunction

   // ==========================================================
   // Derived timing
   always_comb begin
      apbAcc = psel && penable && !stReg.pready;
      singleMode = stReg.ctrl[RSFT_MODE_BIT];
      rowLen = 18'(stReg.act.vcw) + 18'(stReg.act.shs) + 18'(stReg.act.shr) + RSFT_ROW_OVH;
      rowEnd = (stReg.clkCnt == rowLen - 18'h00001);
      rowStep = stepOf(stReg.act.subs[RSFT_SUB_ROW_LSB +: 2], stReg.act.subs[RSFT_SUB_BAYER_BIT]);
      colStep = stepOf(stReg.act.subs[RSFT_SUB_COL_LSB +: 2], stReg.act.subs[RSFT_SUB_BAYER_BIT]);
      rowOff = stReg.readRowN - stReg.act.wRow;
      colOff = stReg.clkCnt[15:0] - stReg.act.wCol;
      readLast = stReg.act.vrd;
      // integration lag in rows, capped at the frame in continuous mode
      // Seventeen bits, so a full-scale count does not wrap to zero
      lagRows = 17'(stReg.act.cint) + 17'h00001;
      if (!singleMode && (lagRows > 17'(stReg.act.vrd) + 17'h00001)) begin
         lagRows = 17'(stReg.act.vrd) + 17'h00001;
      end
   end

   // ==========================================================
   // Next state
   always_comb begin
      stNext = stReg;
      stNext.integStart = 1'b0;
      stNext.readStart = 1'b0;
      stNext.pix.frameStart = 1'b0;
      stNext.pix.rowStart = 1'b0;
      // No stale pixel may stand while the sequencer is idle
      stNext.pix.valid = 1'b0;
      // Sync: three flops, change counts when second and third agree
      stNext.syncPipe = {stReg.syncPipe[1:0], frameSync};
      if (stReg.syncPipe[1] == stReg.syncPipe[2]) begin
         stNext.syncLvl = stReg.syncPipe[2];
      end
      // rising edge once, dropped while a frame runs
      if (stNext.syncLvl && !stReg.syncLvl && stReg.phase == RSFT_IDLE) begin
         stNext.syncPend = 1'b1;
      end
      // APB slave, one wait state
      stNext.pready = 1'b0;
      stNext.pslverr = 1'b0;
      if (apbAcc) begin
         stNext.pready = 1'b1;
         stNext.prdata = 32'h00000000;
         if (pwrite) begin
            unique case (paddr)
               RSFT_CTRL_OFF: stNext.ctrl = pwdata[7:0];
               RSFT_SUBS_OFF: stNext.sw.subs = pwdata[6:0];
               RSFT_INT_MSB_OFF: stNext.sw.cint[15:8] = pwdata[7:0];
               RSFT_INT_LSB_OFF: stNext.sw.cint[7:0] = pwdata[7:0];
               RSFT_VRD_MSB_OFF: stNext.sw.vrd[15:8] = pwdata[7:0];
               RSFT_VRD_LSB_OFF: stNext.sw.vrd[7:0] = pwdata[7:0];
               RSFT_VCW_MSB_OFF: stNext.sw.vcw[15:8] = pwdata[7:0];
               RSFT_VCW_LSB_OFF: stNext.sw.vcw[7:0] = pwdata[7:0];
               RSFT_SHS_OFF: stNext.sw.shs = pwdata[7:0];
               RSFT_SHR_OFF: stNext.sw.shr = pwdata[7:0];
               RSFT_WROW_OFF: stNext.sw.wRow = pwdata[15:0];
               RSFT_WCOL_OFF: stNext.sw.wCol = pwdata[15:0];
               RSFT_WDEP_OFF: stNext.sw.wDep = pwdata[15:0];
               RSFT_WWID_OFF: stNext.sw.wWid = pwdata[15:0];
               RSFT_STAT_OFF: stNext.pslverr = 1'b0;
               default: stNext.pslverr = 1'b1;
            endcase
         end else begin
            unique case (paddr)
               RSFT_CTRL_OFF: stNext.prdata = {24'h000000, stReg.ctrl};
               RSFT_SUBS_OFF: stNext.prdata = {25'h0000000, stReg.sw.subs};
               RSFT_INT_MSB_OFF: stNext.prdata = {24'h000000, stReg.sw.cint[15:8]};
               RSFT_INT_LSB_OFF: stNext.prdata = {24'h000000, stReg.sw.cint[7:0]};
               RSFT_VRD_MSB_OFF: stNext.prdata = {24'h000000, stReg.sw.vrd[15:8]};
               RSFT_VRD_LSB_OFF: stNext.prdata = {24'h000000, stReg.sw.vrd[7:0]};
               RSFT_VCW_MSB_OFF: stNext.prdata = {24'h000000, stReg.sw.vcw[15:8]};
               RSFT_VCW_LSB_OFF: stNext.prdata = {24'h000000, stReg.sw.vcw[7:0]};
               RSFT_SHS_OFF: stNext.prdata = {24'h000000, stReg.sw.shs};
               RSFT_SHR_OFF: stNext.prdata = {24'h000000, stReg.sw.shr};
               RSFT_WROW_OFF: stNext.prdata = {16'h0000, stReg.sw.wRow};
               RSFT_WCOL_OFF: stNext.prdata = {16'h0000, stReg.sw.wCol};
               RSFT_WDEP_OFF: stNext.prdata = {16'h0000, stReg.sw.wDep};
               RSFT_WWID_OFF: stNext.prdata = {16'h0000, stReg.sw.wWid};
               RSFT_STAT_OFF: stNext.prdata = {12'h000, stReg.readRowN, 1'b0,
                                               stReg.readActive, stReg.phase};
               default: stNext.pslverr = 1'b1;
            endcase
         end
      end
      // Sequencer; row counter runs one row time per virtual row
      unique case (stReg.phase)
         RSFT_IDLE: begin
            stNext.clkCnt = 18'h00000;
            stNext.readActive = 1'b0;
            // single waits for sync, continuous starts at once
            if (!singleMode || stReg.syncPend) begin
               stNext.syncPend = 1'b0;
               stNext.act = stReg.sw;
               stNext.phase = RSFT_INTEG;
               stNext.rowCnt = 16'h0000;
               stNext.intCnt = 16'h0000;
               stNext.integRun = 1'b1;
               stNext.lagRun = 1'b1;
               stNext.integStart = 1'b1;
               stNext.integRow = 16'h0000;
            end
         end
         RSFT_INTEG, RSFT_READ: begin
            stNext.clkCnt = rowEnd ? 18'h00000 : stReg.clkCnt + 18'h00001;
            // window pixel output during the readout row
            stNext.pix.valid = stReg.readActive && stReg.clkCnt[17:16] == 2'b00 &&
               stReg.clkCnt[15:0] >= stReg.act.wCol && colOff < stReg.act.wWid &&
               stReg.readRowN >= stReg.act.wRow && rowOff < stReg.act.wDep &&
               inSample(rowOff, rowStep, stReg.act.subs[RSFT_SUB_BAYER_BIT]) &&
               inSample(colOff, colStep, stReg.act.subs[RSFT_SUB_BAYER_BIT]);
            stNext.pix.row = stReg.readRowN;
            stNext.pix.col = stReg.clkCnt[15:0];
            if (rowEnd) begin
               stNext.intCnt = stReg.intCnt + 16'h0001;
               // the last row's read time ends here
               if (stReg.readActive && stReg.readRowN == readLast) begin
                  stNext.readActive = 1'b0;
               end
               // row 0 reads once this frame's lag has run
               // A shorter lag in the next frame cuts the old frame's last reads short
               if (stReg.lagRun && 17'(stReg.intCnt) + 17'h00001 >= lagRows) begin
                  stNext.lagRun = 1'b0;
                  stNext.phase = RSFT_READ;
                  stNext.readActive = 1'b1;
                  stNext.readStart = 1'b1;
                  stNext.readRowN = 16'h0000;
                  stNext.pix.rowStart = 1'b1;
                  stNext.pix.frameStart = 1'b1;
               end else if (stReg.readActive && stReg.readRowN != readLast) begin
                  // later rows follow one row time apart
                  stNext.readStart = 1'b1;
                  stNext.readRowN = stReg.readRowN + 16'h0001;
                  stNext.pix.rowStart = 1'b1;
               end
               // Integration rows; in continuous mode the last row wraps to a new frame
               if (stReg.integRun) begin
                  if (stReg.rowCnt < stReg.act.vrd) begin
                     stNext.rowCnt = stReg.rowCnt + 16'h0001;
                     stNext.integStart = 1'b1;
                     stNext.integRow = stReg.rowCnt + 16'h0001;
                  end else if (!singleMode) begin
                     // next frame rolls in while the old one finishes reading
                     stNext.act = stReg.sw;
                     stNext.rowCnt = 16'h0000;
                     stNext.intCnt = 16'h0000;
                     stNext.lagRun = 1'b1;
                     stNext.integStart = 1'b1;
                     stNext.integRow = 16'h0000;
                  end else begin
                     stNext.integRun = 1'b0;
                  end
               end
               // a single frame is over once nothing is left to integrate or read
               if (!stNext.integRun && !stNext.lagRun && !stNext.readActive) begin
                  stNext.phase = RSFT_IDLE;
               end
            end
         end
      endcase
      if (!rst_n) begin
         stNext = '0;
         stNext.ctrl = RSFT_CTRL_RST;
         stNext.sw = '{vrd: RSFT_VRD_RST, vcw: RSFT_VCW_RST, cint: RSFT_INT_RST,
                       shs: RSFT_SH_RST, shr: RSFT_SH_RST, wRow: RSFT_WIN_RST,
                       wCol: RSFT_WIN_RST, wDep: RSFT_WSIZE_RST, wWid: RSFT_WSIZE_RST,
                       subs: RSFT_SUBS_RST};
         stNext.act = stNext.sw;
         stNext.phase = RSFT_IDLE;
      end
   end

   // State register; reset is folded into the next-state logic
   always_ff @(posedge sys_clk) begin
      stReg <= stNext;
   end

   // Outputs straight from flops
   assign prdata = stReg.prdata;
   assign pready = stReg.pready;
   assign pslverr = stReg.pslverr;
   assign integStart = stReg.integStart;
   assign integRow = stReg.integRow;
   assign readStart = stReg.readStart;
   assign readRow = stReg.readRowN;
   assign pixOut = stReg.pix;

   // ==========================================================
   // Assertions
   single_waits_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      $rose(stReg.phase == RSFT_INTEG) && $past(stReg.phase) == RSFT_IDLE && singleMode
      |-> $past(stReg.syncPend)) else $error("single frame started without sync");
   read_after_int_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      readStart |-> stReg.lagRun || readRow <= stReg.rowCnt)
      else $error("row read before integrating");
   idle_after_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      stReg.phase == RSFT_IDLE && singleMode && !stReg.syncPend |=> stReg.phase == RSFT_IDLE)
      else $error("single frame restarted without sync");
   window_only_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      pixOut.valid |-> pixOut.col >= stReg.act.wCol && pixOut.row >= stReg.act.wRow)
      else $error("pixel outside window");
   row_len_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      stReg.phase != RSFT_IDLE |-> stReg.clkCnt < rowLen) else $error("row time overrun");
   cap_int_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      !singleMode && stReg.lagRun |-> stReg.intCnt <= stReg.act.vrd)
      else $error("integration over frame");
   latch_cfg_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      stReg.phase != RSFT_IDLE && $past(stReg.phase) != RSFT_IDLE
      |-> $stable(stReg.act) || (integStart && integRow == 16'h0000))
      else $error("settings changed mid frame");
   sync_once_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      stReg.phase != RSFT_IDLE && $past(stReg.phase) != RSFT_IDLE |-> !$rose(stReg.syncPend))
      else $error("sync taken mid frame");
   apb_ready_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      psel && penable && !pready |=> pready) else $error("apb answer late");
   cont_start_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      stReg.phase == RSFT_IDLE && !singleMode |=> integStart) else $error("no auto frame start");
   frame_cov_c: cover property (@(posedge sys_clk) pixOut.frameStart);
   single_cov_c: cover property (@(posedge sys_clk) singleMode && stReg.syncPend);
   pixel_cov_c: cover property (@(posedge sys_clk) pixOut.valid);
   bayer_cov_c: cover property (@(posedge sys_clk) stReg.act.subs == 7'h15 && pixOut.valid);
endmodule
`default_nettype wire

// ===== logic/rsft_pkg.sv
// Package for the rolling shutter frame timing block: register map, fields, resets, constants
package rsft_pkg;
   // Register byte offsets (one aligned word each)
   localparam logic [7:0] RSFT_CTRL_OFF = 8'h00;
   localparam logic [7:0] RSFT_SUBS_OFF = 8'h04;
   localparam logic [7:0] RSFT_INT_MSB_OFF = 8'h08;
   localparam logic [7:0] RSFT_INT_LSB_OFF = 8'h0c;
   localparam logic [7:0] RSFT_VRD_MSB_OFF = 8'h10;
   localparam logic [7:0] RSFT_VRD_LSB_OFF = 8'h14;
   localparam logic [7:0] RSFT_VCW_MSB_OFF = 8'h18;
   localparam logic [7:0] RSFT_VCW_LSB_OFF = 8'h1c;
   localparam logic [7:0] RSFT_SHS_OFF = 8'h20;
   localparam logic [7:0] RSFT_SHR_OFF = 8'h24;
   localparam logic [7:0] RSFT_WROW_OFF = 8'h28;
   localparam logic [7:0] RSFT_WCOL_OFF = 8'h2c;
   localparam logic [7:0] RSFT_WDEP_OFF = 8'h30;
   localparam logic [7:0] RSFT_WWID_OFF = 8'h34;
   localparam logic [7:0] RSFT_STAT_OFF = 8'h38;
   // Field positions
   localparam int RSFT_MODE_BIT = 6;
   localparam int RSFT_SUB_BAYER_BIT = 4;
   localparam int RSFT_SUB_ROW_LSB = 2;
   localparam int RSFT_SUB_COL_LSB = 0;
   // Widths of split values and of their pieces
   localparam int RSFT_HALF_W = 8;
   localparam int RSFT_CNT_W = 16;
   // Reset values
   localparam logic [7:0] RSFT_CTRL_RST = 8'h00;
   localparam logic [6:0] RSFT_SUBS_RST = 7'h00;
   localparam logic [15:0] RSFT_VRD_RST = 16'h0007;
   localparam logic [15:0] RSFT_VCW_RST = 16'h0007;
   localparam logic [15:0] RSFT_INT_RST = 16'h0002;
   localparam logic [7:0] RSFT_SH_RST = 8'h01;
   localparam logic [15:0] RSFT_WIN_RST = 16'h0000;
   localparam logic [15:0] RSFT_WSIZE_RST = 16'h0004;
   // Fixed row overhead in master clocks
   localparam logic [17:0] RSFT_ROW_OVH = 18'h00013;

   typedef enum logic [1:0] {RSFT_IDLE, RSFT_INTEG, RSFT_READ} rsft_phase_e;

   // Frame settings, latched at frame boundaries
   typedef struct packed {
      logic [15:0] vrd;
      logic [15:0] vcw;
      logic [15:0] cint;
      logic [7:0] shs;
      logic [7:0] shr;
      logic [15:0] wRow;
      logic [15:0] wCol;
      logic [15:0] wDep;
      logic [15:0] wWid;
      logic [6:0] subs;
   } rsft_cfg_s;

   // Pixel stream towards the readout path
   typedef struct packed {
      logic valid;
      logic frameStart;
      logic rowStart;
      logic [15:0] row;
      logic [15:0] col;
   } rsft_pix_s;
endpackage

// ===== verification/rsft_host_model.sv
// Host controller model: APB master for the settings and frame sync source
`timescale 1ns/10ps
`default_nettype none
module rsft_host_model (
   input wire logic sys_clk, // Master clock
   input wire logic [31:0] prdata, // Read data
   input wire logic pready, // Slave ready
   input wire logic pslverr, // Slave error
   output logic psel, // Select
   output logic penable, // Enable
   output logic pwrite, // Direction
   output logic [7:0] paddr, // Byte address
   output logic [31:0] pwdata, // Write data
   output logic frameSync // Frame sync to the sensor
);
   // Quiet bus and no sync at time zero
   initial begin
      {psel, penable, pwrite, paddr, pwdata, frameSync} = '0;
   end
   // ==========================================
   // Bus cycle: request held until pready is sampled high
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic e);
      @(posedge sys_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      // Slave latency is not assumed; the bench timeout ends a hang
      do @(posedge sys_clk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // ==========================================
   // sync held two clocks
   task automatic syncPulse();
      @(posedge sys_clk);
      frameSync <= 1'b1;
      repeat (2) @(posedge sys_clk);
      frameSync <= 1'b0;
   endtask
endmodule
`default_nettype wire

// ===== verification/tb_top.sv
// Testbench: scenarios for the frame timing sequencer
`timescale 1ns/10ps
`default_nettype none
module tb_top
   import rsft_pkg::*;
;
   logic sys_clk, rst_n, psel, penable, pwrite, pready, pslverr, frameSync, err;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic integStart, readStart;
   logic [15:0] integRow, readRow, colMask;
   rsft_pix_s pixOut;
   int failures = 0, checks_done = 0, cyc = 0, intCnt = 0, int0Cnt = 0, rd0Cnt = 0;
   int tInt0 = 0, tInt1 = 0, tRd0 = 0, tRdL = 0, pixCnt = 0, pixBad = 0, tRel = 0;
   int wR = 0, wC = 0, wD = 4, wW = 4;
   rsft_frame_timing u_rsft_frame_timing (.sys_clk, .rst_n, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .frameSync, .integStart, .integRow,
      .readStart, .readRow, .pixOut);
   rsft_host_model u_host (.sys_clk, .prdata, .pready, .pslverr, .psel, .penable,
      .pwrite, .paddr, .pwdata, .frameSync);
   // Clock, 50 ns period
   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end
   // ==========================================
   // Monitor: event times and per-frame pixel tallies
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (integStart === 1'b1) begin
         intCnt <= intCnt + 1;
         if (integRow === 16'h0000) begin
            int0Cnt <= int0Cnt + 1;
            tInt0 <= cyc;
         end
         if (integRow === 16'h0001) tInt1 <= cyc;
      end
      if (readStart === 1'b1 && readRow === 16'h0000) begin
         rd0Cnt <= rd0Cnt + 1;
         tRd0 <= cyc;
      end
      if (readStart === 1'b1 && readRow === 16'h0007) tRdL <= cyc;
      if (pixOut.frameStart === 1'b1) begin
         pixCnt <= (pixOut.valid === 1'b1) ? 1 : 0;
         colMask <= (pixOut.valid === 1'b1) ? (16'h1 << pixOut.col[3:0]) : 16'h0;
      end else if (pixOut.valid === 1'b1) begin
         pixCnt <= pixCnt + 1;
         colMask <= colMask | (16'h1 << pixOut.col[3:0]);
      end
      if (pixOut.valid === 1'b1 && (pixOut.row < wR || pixOut.row >= wR + wD ||
         pixOut.col < wC || pixOut.col >= wC + wW)) pixBad <= pixBad + 1;
   end
   // Hang guard, well above the expected run length
   always @(posedge sys_clk) begin
      if (cyc == 80000) begin
         failures++;
         close_out();
      end
   end
   // ==========================================
   task automatic close_out();
      $display("Checks made %0d, mismatches %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         failures++;
         $display("[ERR] %s expected %0h seen %0h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      u_host.xfer(1'b1, a, d, q, err);
   endtask
   task automatic rd(input logic [7:0] a);
      u_host.xfer(1'b0, a, 32'h0, q, err);
   endtask
   task automatic wr16(input logic [7:0] m, input logic [7:0] l, input logic [15:0] v);
      wr(m, {24'h0, v[15:8]});
      wr(l, {24'h0, v[7:0]});
   endtask
   task automatic wait_idle();
      for (int i = 0; i < 3000; i++) begin
         rd(RSFT_STAT_OFF);
         if (q[1:0] === 2'b00) break;
      end
   endtask
   // Next row 0 integration start; its time is returned
   task automatic next_frame(output int t);
      int k;
      k = int0Cnt;
      wait (int0Cnt == k + 1);
      @(negedge sys_clk);
      t = tInt0;
   endtask
   task automatic next_read();
      int r;
      r = rd0Cnt;
      wait (rd0Cnt == r + 1);
      @(negedge sys_clk);
   endtask
   task automatic frame_run();
      int t;
      u_host.syncPulse();
      next_frame(t);
      wait_idle();
   endtask
   task automatic set_win(input int r, input int c, input int d, input int w, input logic [6:0] s);
      wR = r;
      wC = c;
      wD = d;
      wW = w;
      wr(RSFT_WROW_OFF, r);
      wr(RSFT_WCOL_OFF, c);
      wr(RSFT_WDEP_OFF, d);
      wr(RSFT_WWID_OFF, w);
      wr(RSFT_SUBS_OFF, {25'h0, s});
      frame_run();
   endtask
   // ==========================================
   task automatic test_reset();
      wait (intCnt > 0);
      @(negedge sys_clk);
      chk("firstRowIsZero", 1, int0Cnt);
      chk("prompt", 1, (tInt0 - tRel) <= 4);
      $display("test_reset done");
   endtask
   task automatic test_regs();
      logic [7:0] a [6] = '{RSFT_CTRL_OFF, RSFT_INT_LSB_OFF, RSFT_VRD_LSB_OFF,
         RSFT_VCW_LSB_OFF, RSFT_SHS_OFF, RSFT_SHR_OFF};
      logic [31:0] e [6] = '{32'h0, 32'h2, 32'h7, 32'h7, 32'h1, 32'h1};
      for (int i = 0; i < 6; i++) begin
         rd(a[i]);
         chk("resetValue", e[i], q);
      end
      wr(RSFT_SUBS_OFF, 32'h4a);
      rd(RSFT_SUBS_OFF);
      chk("subsBack", 32'h4a, q);
      wr(RSFT_SUBS_OFF, 32'h0);
      rd(8'h3c);
      chk("unmappedErr", 1, err);
      chk("unmappedData", 0, q);
      $display("test_regs done");
   endtask
   // Defaults: row time 7+1+1+19 = 28 clocks, lag 3 rows, 8 rows
   task automatic test_cont();
      int t0, t1;
      next_frame(t0);
      next_read();
      chk("rowTime", 28, tInt1 - t0);
      chk("integLag", 3 * 28, tRd0 - t0);
      next_frame(t1);
      chk("framePeriod", 8 * 28, t1 - t0);
      wr16(RSFT_INT_MSB_OFF, RSFT_INT_LSB_OFF, 16'd100);
      next_frame(t0);
      next_read();
      chk("cappedLag", 8 * 28, tRd0 - t0);
      $display("test_cont done");
   endtask
   // Single frame: cint 20, shs 5, so row time 32 clocks
   task automatic test_single();
      int n, t0;
      wr(RSFT_CTRL_OFF, 32'h40);
      wait_idle();
      n = intCnt;
      repeat (300) @(posedge sys_clk);
      @(negedge sys_clk);
      chk("waitsForSync", n, intCnt);
      wr16(RSFT_INT_MSB_OFF, RSFT_INT_LSB_OFF, 16'd20);
      wr(RSFT_SHS_OFF, 32'h5);
      n = int0Cnt;
      u_host.syncPulse();
      repeat (10) @(posedge sys_clk);
      @(negedge sys_clk);
      chk("syncStarts", n + 1, int0Cnt);
      t0 = tInt0;
      // A second sync inside the frame must be dropped
      u_host.syncPulse();
      wait_idle();
      chk("singleLag", 21 * 32, tRd0 - t0);
      chk("singleFrame", 28 * 32, tRdL - t0);
      repeat (300) @(posedge sys_clk);
      @(negedge sys_clk);
      chk("onePerSync", n + 1, int0Cnt);
      $display("test_single done");
   endtask
   task automatic test_window();
      logic [15:0] m;
      wr16(RSFT_INT_MSB_OFF, RSFT_INT_LSB_OFF, 16'd0);
      wr(RSFT_SHS_OFF, 32'h1);
      wr16(RSFT_VCW_MSB_OFF, RSFT_VCW_LSB_OFF, 16'd31);
      set_win(2, 3, 3, 5, 7'h00);
      chk("winCount", 15, pixCnt);
      for (int r = 0; r < 4; r++) begin
         set_win(0, 0, 1, 16, 7'(r));
         m = 16'h0;
         for (int c = 0; c < 16; c += (1 << r)) m[c] = 1'b1;
         chk("colMask", m, colMask);
         chk("colCount", 16 >> r, pixCnt);
      end
      set_win(0, 0, 8, 1, 7'h08);
      chk("rowQuarter", 2, pixCnt);
      set_win(0, 0, 1, 16, 7'h11);
      chk("bayerHalf", 16'h3333, colMask);
      set_win(0, 0, 1, 16, 7'h15);
      chk("bayerSkipOne", 16'h3333, colMask);
      chk("outsideWin", 0, pixBad);
      $display("test_window done");
   endtask
   // ==========================================
   // Main sequence
   initial begin
      rst_n = 1'b0;
      repeat (10) @(posedge sys_clk);
      rst_n <= 1'b1;
      tRel = cyc;
      test_reset();
      test_regs();
      test_cont();
      test_single();
      test_window();
      close_out();
   end
endmodule
`default_nettype wire
